/* File: chan_query_pkg.sv */
package chan_query_pkg;
    // Register offsets, byte addresses on the plain register port
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RES0 = 8'h08;
    localparam logic [7:0] REG_RES1 = 8'h0c;
    localparam logic [7:0] REG_RES2 = 8'h10;
    // Command word fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_CHAN_LSB = 8;
    localparam int CMD_SEL_BIT = 16;
    // Status word fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_ERR_LSB = 4;
    localparam int ST_CNT_LSB = 8;
    // Query command codes
    localparam logic [7:0] OPC_STATUS = 8'h08;
    localparam logic [7:0] OPC_DATA = 8'h09;
    // Channel numbers accepted by both queries
    localparam logic [7:0] CH_ANALOG_FIRST = 8'h01;
    localparam logic [7:0] CH_ANALOG_LAST = 8'h04;
    localparam logic [7:0] CH_SONIC1 = 8'h0b;
    localparam logic [7:0] CH_SONIC2 = 8'h0c;
    localparam int NUM_CH = 6;
    localparam logic [2:0] IDX_ANALOG1 = 3'h0;
    localparam logic [2:0] IDX_SONIC1 = 3'h4;
    localparam logic [2:0] IDX_SONIC2 = 3'h5;
    // Operations of the first channel that have no meaningful reading
    localparam logic [7:0] OP_NODATA_FIRST = 8'h05;
    localparam logic [7:0] OP_NODATA_LAST = 8'h07;
    // Error codes
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_CHANNEL = 4'h1;
    localparam logic [3:0] ERR_COMMAND = 4'h2;
    // Number of returned values
    localparam logic [1:0] CNT_NONE = 2'h0;
    localparam logic [1:0] CNT_DATA = 2'h1;
    localparam logic [1:0] CNT_STATUS = 2'h3;
    // Reset and filler values
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [7:0] OP_RESET = 8'h00;
    // Query engine states
    typedef enum logic [0:0] {ST_IDLE, ST_WAIT_ID} query_state_t;
endpackage : chan_query_pkg

/* File: channel_status_query.sv */
`timescale 1ns/1ns
module channel_status_query #(
    parameter logic [31:0] NO_DATA_VALUE = 32'hffff_fc19 // Marker for "no valid reading"
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic setup_valid,
    input wire logic [7:0] setup_channel,
    input wire logic [7:0] setup_op,
    input wire logic sample_valid,
    input wire logic [7:0] sample_channel,
    input wire logic [31:0] sample_data,
    input wire logic [31:0] sample_posn,
    output logic id_req,
    output logic [7:0] id_channel,
    input wire logic id_ack,
    input wire logic [31:0] id_value
);
    // Map a channel number onto a storage index, flagging unknown numbers
    function automatic logic [3:0] chan_map(input logic [7:0] ch);
        logic [7:0] off;
        off = ch - chan_query_pkg::CH_ANALOG_FIRST;
        if (ch >= chan_query_pkg::CH_ANALOG_FIRST && ch <= chan_query_pkg::CH_ANALOG_LAST)
            return {1'b1, off[2:0]};
        else if (ch == chan_query_pkg::CH_SONIC1)
            return {1'b1, chan_query_pkg::IDX_SONIC1};
        else if (ch == chan_query_pkg::CH_SONIC2)
            return {1'b1, chan_query_pkg::IDX_SONIC2};
        else
            return 4'h0;
    endfunction : chan_map

    // Per-channel storage
    logic [7:0] op_reg [chan_query_pkg::NUM_CH]; // Operation from last setup
    logic [31:0] live_data [chan_query_pkg::NUM_CH]; // Latest valid reading
    logic [31:0] live_posn [chan_query_pkg::NUM_CH]; // Its sample position
    logic live_seen [chan_query_pkg::NUM_CH]; // A reading exists
    logic [31:0] snap_data [chan_query_pkg::NUM_CH]; // Copy taken at setup
    logic [31:0] snap_posn [chan_query_pkg::NUM_CH];
    logic snap_seen [chan_query_pkg::NUM_CH];
    logic [31:0] id_store [chan_query_pkg::NUM_CH]; // Last identity value

    // Query engine state and answer registers
    chan_query_pkg::query_state_t state;
    logic [31:0] cmd_word; // Last accepted command word
    logic [31:0] res0;
    logic [31:0] res1;
    logic [31:0] res2;
    logic [3:0] err_code;
    logic [1:0] res_count;
    logic done;
    logic [2:0] pend_idx; // Channel waiting on an identity retest

    // Decode of the incoming command word
    wire [7:0] wr_code = wdata[chan_query_pkg::CMD_CODE_LSB +: 8];
    wire [7:0] wr_chan = wdata[chan_query_pkg::CMD_CHAN_LSB +: 8];
    wire wr_sel = wdata[chan_query_pkg::CMD_SEL_BIT];
    wire [3:0] wr_map = chan_map(wr_chan);
    wire wr_ok = wr_map[3];
    wire [2:0] wr_idx = wr_map[2:0];
    wire cmd_take = wr && addr == chan_query_pkg::REG_CMD && state == chan_query_pkg::ST_IDLE;
    wire take_status = cmd_take && wr_ok && wr_code == chan_query_pkg::OPC_STATUS;
    wire take_data = cmd_take && wr_ok && wr_code == chan_query_pkg::OPC_DATA;
    wire [3:0] setup_map = chan_map(setup_channel);
    wire [3:0] sample_map = chan_map(sample_channel);

    // Source selection for the status query
    wire [31:0] pick_data = wr_sel ? snap_data[wr_idx] : live_data[wr_idx];
    wire [31:0] pick_posn = wr_sel ? snap_posn[wr_idx] : live_posn[wr_idx];
    wire pick_seen = wr_sel ? snap_seen[wr_idx] : live_seen[wr_idx];
    wire [7:0] pick_op = op_reg[wr_idx];
    // First channel in a counting/timing operation has no analog reading
    wire op_nodata = wr_idx == chan_query_pkg::IDX_ANALOG1
        && pick_op >= chan_query_pkg::OP_NODATA_FIRST
        && pick_op <= chan_query_pkg::OP_NODATA_LAST;
    wire [31:0] ans_data = (op_nodata || !pick_seen) ? NO_DATA_VALUE : pick_data;
    wire [31:0] ans_posn = pick_seen ? pick_posn : chan_query_pkg::WORD_ZERO;

    // Status word and read decode
    wire [31:0] status_word = {16'h0000, 6'h00, res_count, err_code, 2'b00, done,
        state == chan_query_pkg::ST_WAIT_ID};
    wire [31:0] read_mux =
        addr == chan_query_pkg::REG_CMD ? cmd_word :
        addr == chan_query_pkg::REG_STATUS ? status_word :
        addr == chan_query_pkg::REG_RES0 ? res0 :
        addr == chan_query_pkg::REG_RES1 ? res1 :
        addr == chan_query_pkg::REG_RES2 ? res2 : chan_query_pkg::WORD_ZERO;

    // Per-channel storage; queries write only id_store, so sampling is never held off
    genvar gi;
    generate
        for (gi = 0; gi < chan_query_pkg::NUM_CH; gi++)
        begin : g_chan
            wire setup_hit = setup_valid && setup_map[3] && setup_map[2:0] == gi;
            wire sample_hit = sample_valid && sample_map[3] && sample_map[2:0] == gi;
            wire id_hit = state == chan_query_pkg::ST_WAIT_ID && id_ack && pend_idx == gi;
            // Setup records the operation and freezes the present readings
            always_ff @(posedge ref_clk)
            begin
                if (srst)
                begin
                    op_reg[gi] <= chan_query_pkg::OP_RESET;
                    snap_data[gi] <= chan_query_pkg::WORD_ZERO;
                    snap_posn[gi] <= chan_query_pkg::WORD_ZERO;
                    snap_seen[gi] <= 1'b0;
                end
                else if (setup_hit)
                begin
                    op_reg[gi] <= setup_op;
                    snap_data[gi] <= live_data[gi];
                    snap_posn[gi] <= live_posn[gi];
                    snap_seen[gi] <= live_seen[gi];
                end
            end
            // Sampling path is written by the collector alone, so a query cannot stall it
            always_ff @(posedge ref_clk)
            begin
                if (srst)
                begin
                    live_data[gi] <= chan_query_pkg::WORD_ZERO;
                    live_posn[gi] <= chan_query_pkg::WORD_ZERO;
                    live_seen[gi] <= 1'b0;
                end
                else if (sample_hit)
                begin
                    live_data[gi] <= sample_data;
                    live_posn[gi] <= sample_posn;
                    live_seen[gi] <= 1'b1;
                end
            end
            // Identity kept until the next retest, even with the sensor unplugged
            always_ff @(posedge ref_clk)
            begin
                if (srst)
                    id_store[gi] <= chan_query_pkg::WORD_ZERO;
                else if (id_hit)
                    id_store[gi] <= id_value;
            end
        end
    endgenerate

    // Command acceptance; writes while a retest is pending are ignored
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cmd_word <= chan_query_pkg::WORD_ZERO;
        else if (cmd_take)
            cmd_word <= wdata;
    end

    // Query engine: status answers and stored identity complete at once
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state <= chan_query_pkg::ST_IDLE;
            res0 <= chan_query_pkg::WORD_ZERO;
            res1 <= chan_query_pkg::WORD_ZERO;
            res2 <= chan_query_pkg::WORD_ZERO;
            err_code <= chan_query_pkg::ERR_NONE;
            res_count <= chan_query_pkg::CNT_NONE;
            done <= 1'b0;
            pend_idx <= 3'h0;
            id_req <= 1'b0;
            id_channel <= 8'h00;
        end
        else
        begin
            id_req <= 1'b0;
            case (state)
                chan_query_pkg::ST_IDLE:
                begin
                    if (cmd_take && !wr_ok)
                    begin
                        // Unknown channel: no values, error recorded instead
                        err_code <= chan_query_pkg::ERR_CHANNEL;
                        res_count <= chan_query_pkg::CNT_NONE;
                        done <= 1'b1;
                    end
                    else if (take_status)
                    begin
                        res0 <= {24'h000000, pick_op};
                        res1 <= ans_data;
                        res2 <= ans_posn;
                        err_code <= chan_query_pkg::ERR_NONE;
                        res_count <= chan_query_pkg::CNT_STATUS;
                        done <= 1'b1;
                    end
                    else if (take_data && wr_sel)
                    begin
                        res0 <= id_store[wr_idx];
                        err_code <= chan_query_pkg::ERR_NONE;
                        res_count <= chan_query_pkg::CNT_DATA;
                        done <= 1'b1;
                    end
                    else if (take_data)
                    begin
                        // Retest asks the front end for a fresh identity reading
                        id_req <= 1'b1;
                        id_channel <= wr_chan;
                        pend_idx <= wr_idx;
                        err_code <= chan_query_pkg::ERR_NONE;
                        res_count <= chan_query_pkg::CNT_NONE;
                        done <= 1'b0;
                        state <= chan_query_pkg::ST_WAIT_ID;
                    end
                    else if (cmd_take)
                    begin
                        err_code <= chan_query_pkg::ERR_COMMAND;
                        res_count <= chan_query_pkg::CNT_NONE;
                        done <= 1'b1;
                    end
                end
                chan_query_pkg::ST_WAIT_ID:
                begin
                    if (id_ack)
                    begin
                        res0 <= id_value;
                        res_count <= chan_query_pkg::CNT_DATA;
                        done <= 1'b1;
                        state <= chan_query_pkg::ST_IDLE;
                    end
                end
                default:
                    state <= chan_query_pkg::ST_IDLE;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            rdata <= chan_query_pkg::WORD_ZERO;
        else
            rdata <= rd ? read_mux : chan_query_pkg::WORD_ZERO;
    end

    // Checks on the answers
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    status_three_a: assert property (take_status
        |=> done && res_count == chan_query_pkg::CNT_STATUS)
        else $error("status query did not give three values");
    op_echo_a: assert property (take_status |=> res0 == {24'h000000, $past(pick_op)})
        else $error("first value differs from setup operation");
    live_source_a: assert property (take_status && !wr_sel
        && live_seen[wr_idx] && !op_nodata |=> res1 == $past(live_data[wr_idx]))
        else $error("live reading not returned");
    snap_posn_a: assert property (take_status && wr_sel && snap_seen[wr_idx]
        |=> res2 == $past(snap_posn[wr_idx]))
        else $error("stored position not returned");
    nodata_mark_a: assert property (take_status && op_nodata |=> res1 == NO_DATA_VALUE)
        else $error("masked reading not marked");
    bad_channel_a: assert property (cmd_take && !wr_ok
        |=> err_code == chan_query_pkg::ERR_CHANNEL && res_count == chan_query_pkg::CNT_NONE)
        else $error("bad channel not rejected");
    retest_req_a: assert property (take_data && !wr_sel
        |=> id_req && state == chan_query_pkg::ST_WAIT_ID ##1 !id_req)
        else $error("retest request missing");
    stored_id_a: assert property (take_data && wr_sel |=> res0 == $past(id_store[wr_idx]))
        else $error("stored identity not returned");
    sample_kept_a: assert property (sample_valid && sample_map[3]
        |=> live_posn[$past(sample_map[2:0])] == $past(sample_posn))
        else $error("sample lost during query");
    id_reply_a: assert property (state == chan_query_pkg::ST_WAIT_ID && id_ack
        |=> res0 == $past(id_value) && done && state == chan_query_pkg::ST_IDLE)
        else $error("identity reply not returned");

    status_query_c: cover property (take_status ##1 rd && addr == chan_query_pkg::REG_RES2);
    retest_c: cover property (take_data && !wr_sel ##[1:20] id_ack);
    query_while_sampling_c: cover property (take_status && sample_valid);
    bad_channel_c: cover property (cmd_take && !wr_ok);
endmodule : channel_status_query

/* File: sensor_front_model.sv */
`timescale 1ns/1ns
// Sensor front end: answers each identity retest after a chosen latency
module sensor_front_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic id_req,
    input wire logic [7:0] id_channel,
    input wire logic [31:0] lat,
    input wire logic [31:0] val,
    output logic id_ack,
    output logic [31:0] id_value
);
    int cnt; // Cycles left before the answer
    // Answer after lat cycles (one cycle if lat is zero); between answers the data line toggles so it is never stale
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            cnt <= 0;
            id_ack <= 1'b0;
            id_value <= 32'h0000_0000;
        end
        else
        begin
            id_ack <= 1'b0;
            id_value <= ~id_value;
            if (id_req)
                cnt <= (lat == 32'h0000_0000) ? 1 : lat;
            else if (cnt == 1)
            begin
                // Immediate sensor value of the retested channel
                id_ack <= 1'b1;
                id_value <= val;
                cnt <= 0;
            end
            else if (cnt > 1)
                cnt <= cnt - 1;
        end
    end
endmodule : sensor_front_model

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
    logic ref_clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic setup_valid = 1'b0, sample_valid = 1'b0;
    logic [7:0] setup_channel = 8'h00, setup_op = 8'h00, sample_channel = 8'h00;
    logic [31:0] sample_data = 32'h0000_0000, sample_posn = 32'h0000_0000;
    logic id_req, id_ack;
    logic [7:0] id_channel;
    logic [31:0] id_value, fe_val = 32'h0000_0000, r;
    int fe_lat = 6, errors = 0, checked = 0;
    logic [7:0] chans [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0b, 8'h0c};
    logic [7:0] bad [6] = '{8'h00, 8'h05, 8'h0a, 8'h0d, 8'h15, 8'hff};
    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;
    channel_status_query channel_status_query_i (.ref_clk(ref_clk), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .setup_valid(setup_valid),
        .setup_channel(setup_channel), .setup_op(setup_op), .sample_valid(sample_valid),
        .sample_channel(sample_channel), .sample_data(sample_data), .sample_posn(sample_posn),
        .id_req(id_req), .id_channel(id_channel), .id_ack(id_ack), .id_value(id_value));
    sensor_front_model sensor_front_model_i (.ref_clk(ref_clk), .srst(srst), .id_req(id_req),
        .id_channel(id_channel), .lat(fe_lat), .val(fe_val), .id_ack(id_ack),
        .id_value(id_value));
    // Command word: selector, channel, code
    function automatic logic [31:0] cmd(logic [7:0] c, logic [7:0] ch, logic s);
        cmd = {15'h0000, s, ch, c};
    endfunction : cmd
    // Expected status word: count, error, done, busy
    function automatic logic [31:0] st(logic b, logic d, logic [3:0] e, logic [1:0] n);
        st = {22'h000000, n, e, 2'h0, d, b};
    endfunction : st
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge ref_clk) wr <= 1'b0;
    endtask : wr_reg
    // Separate retrieval after each query; data stands one cycle after the strobe
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk) {rd, addr} <= {1'b1, a};
        @(posedge ref_clk) rd <= 1'b0;
        #1 chk(nm, exp, rdata);
    endtask : rd_chk
    task automatic setup(input logic [7:0] ch, input logic [7:0] op);
        @(posedge ref_clk) {setup_valid, setup_channel, setup_op} <= {1'b1, ch, op};
        @(posedge ref_clk) setup_valid <= 1'b0;
    endtask : setup
    task automatic smp(input logic [7:0] ch, input logic [31:0] d, input logic [31:0] p);
        @(posedge ref_clk)
            {sample_valid, sample_channel, sample_data, sample_posn} <= {1'b1, ch, d, p};
        @(posedge ref_clk) sample_valid <= 1'b0;
    endtask : smp
    // Poll done with a bound; a retest must not hang forever
    task automatic wait_done();
        int i;
        i = 0;
        r = 32'h0000_0000;
        while (r[1] !== 1'b1 && i < 40)
        begin
            @(posedge ref_clk) {rd, addr} <= {1'b1, chan_query_pkg::REG_STATUS};
            @(posedge ref_clk) rd <= 1'b0;
            #1 r = rdata;
            i++;
        end
        chk("retest done", 32'h0000_0001, {31'h0, r[1]});
    endtask : wait_done
    task automatic t_live();
        foreach (chans[i])
        begin
            setup(chans[i], chans[i] + 8'h20);
            smp(chans[i], {24'h000001, chans[i]}, {24'h0, chans[i]} + 32'h1);
            wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_STATUS, chans[i], 1'b0));
            rd_chk("status", chan_query_pkg::REG_STATUS, st(0, 1, 4'h0, 2'h3));
            rd_chk("operation", chan_query_pkg::REG_RES0, {24'h0, chans[i] + 8'h20});
            rd_chk("lastdata", chan_query_pkg::REG_RES1, {24'h000001, chans[i]});
            rd_chk("lastposn", chan_query_pkg::REG_RES2, {24'h0, chans[i]} + 32'h1);
        end
        // A query in the very cycle of a sample sees the older reading, and the sample lands
        fork
            smp(8'h01, 32'h0000_5678, 32'h0000_0007);
            wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_STATUS, 8'h01, 1'b0));
        join
        rd_chk("same cycle data", chan_query_pkg::REG_RES1, 32'h0000_0101);
        rd_chk("same cycle posn", chan_query_pkg::REG_RES2, 32'h0000_0002);
        wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_STATUS, 8'h01, 1'b0));
        rd_chk("later data", chan_query_pkg::REG_RES1, 32'h0000_5678);
        rd_chk("later posn", chan_query_pkg::REG_RES2, 32'h0000_0007);
        $display("test live status finished");
    endtask : t_live
    task automatic t_copy();
        smp(8'h0b, 32'h0000_aaaa, 32'h0000_0002);
        setup(8'h0b, 8'h03);
        smp(8'h0b, 32'h0000_bbbb, 32'h0000_0003);
        wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_STATUS, 8'h0b, 1'b1));
        rd_chk("copy op", chan_query_pkg::REG_RES0, 32'h0000_0003);
        rd_chk("copy data", chan_query_pkg::REG_RES1, 32'h0000_aaaa);
        rd_chk("copy posn", chan_query_pkg::REG_RES2, 32'h0000_0002);
        wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_STATUS, 8'h0b, 1'b0));
        rd_chk("live data", chan_query_pkg::REG_RES1, 32'h0000_bbbb);
        for (int op = 5; op <= 7; op++)
        begin
            setup(8'h01, op[7:0]);
            wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_STATUS, 8'h01, 1'b0));
            rd_chk("no reading", chan_query_pkg::REG_RES1, 32'hffff_fc19);
        end
        $display("test setup copy finished");
    endtask : t_copy
    task automatic t_data();
        fe_lat = 6;
        fe_val = 32'h1943_8300;
        wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_DATA, 8'h02, 1'b0));
        rd_chk("busy", chan_query_pkg::REG_STATUS, st(1, 0, 4'h0, 2'h0));
        // Refused while the retest is pending
        wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_STATUS, 8'h03, 1'b0));
        wait_done();
        rd_chk("retest value", chan_query_pkg::REG_RES0, 32'h1943_8300);
        rd_chk("one value", chan_query_pkg::REG_STATUS, st(0, 1, 4'h0, 2'h1));
        rd_chk("cmd kept", chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_DATA, 8'h02, 1'b0));
        chk("retest channel", 32'h0000_0002, {24'h0, id_channel});
        fe_val = 32'h2195_3600;
        wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_DATA, 8'h02, 1'b1));
        rd_chk("stored id", chan_query_pkg::REG_RES0, 32'h1943_8300);
        fe_lat = 1;
        wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_DATA, 8'h0c, 1'b0));
        wait_done();
        rd_chk("prompt retest", chan_query_pkg::REG_RES0, 32'h2195_3600);
        $display("test data query finished");
    endtask : t_data
    task automatic t_bad();
        foreach (bad[i])
        begin
            wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_STATUS, bad[i], 1'b0));
            rd_chk("bad chan", chan_query_pkg::REG_STATUS, st(0, 1, 4'h1, 2'h0));
        end
        wr_reg(chan_query_pkg::REG_CMD, cmd(chan_query_pkg::OPC_DATA, 8'h0d, 1'b1));
        rd_chk("bad data chan", chan_query_pkg::REG_STATUS, st(0, 1, 4'h1, 2'h0));
        rd_chk("kept result", chan_query_pkg::REG_RES0, 32'h2195_3600);
        wr_reg(chan_query_pkg::REG_CMD, cmd(8'h07, 8'h01, 1'b0));
        rd_chk("bad code", chan_query_pkg::REG_STATUS, st(0, 1, 4'h2, 2'h0));
        rd_chk("unmapped", 8'h14, 32'h0000_0000);
        $display("test bad queries finished");
    endtask : t_bad
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // About 200 cycles of tests; the watchdog allows 7000 cycles, some 35 times that
    initial
    begin
        #56000;
        errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        rd_chk("reset status", chan_query_pkg::REG_STATUS, 32'h0000_0000);
        chk("reset request", 32'h0000_0000, {31'h0, id_req});
        chk("reset channel", 32'h0000_0000, {24'h0, id_channel});
        t_live();
        t_copy();
        t_data();
        t_bad();
        tally_and_finish();
    end
endmodule : tb
